// file: hdl/irfo_top.sv
// Interrupt request flag output stage: flags, cause enables, polarity and pin driver, with AXI4-Lite registers.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module irfo_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic awFromCore,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic intRequest,
  output logic extRequestPinOut,
  output logic extRequestPinOe_n,
  output logic irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : lane_mask

  function automatic logic known_offset(input logic [15:0] a);
    logic hit;
    hit = (a == irfo_pkg::OFS_FLAGS_DIRECT) || (a == irfo_pkg::OFS_FLAGS_SETCLR) ||
          (a == irfo_pkg::OFS_FLAG_POL) || (a == irfo_pkg::OFS_OUT_CTRL) ||
          (a == irfo_pkg::OFS_INT_ENABLE) || (a == irfo_pkg::OFS_EXT_ENABLE) ||
          (a == irfo_pkg::OFS_EVT_STATUS) || (a == irfo_pkg::OFS_EVT_MASK);
    return hit;
  endfunction : known_offset

  // Byte lanes that the strobe leaves out keep their old bits.
  function automatic logic [15:0] merge_lanes(input logic [15:0] old, input logic [15:0] lanes,
    input logic [15:0] bits);
    logic [15:0] merged;
    merged = (old & ~lanes) | (bits & lanes);
    return merged;
  endfunction : merge_lanes

  function automatic logic any_cause(input logic [15:0] level, input logic [15:0] enables);
    logic hit;
    hit = |(level & enables);
    return hit;
  endfunction : any_cause

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  logic wrEn;
  logic [15:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrCore;
  logic wrOk;
  logic rdEn;
  logic [15:0] rdAddr;
  logic [31:0] rdData;
  logic rdOk;

  irfo_axil_slave irfo_axil_slave_i (
    .clk(clk),
    .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .awFromCore(awFromCore),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrCore(wrCore),
    .wrOk(wrOk),
    .rdEn(rdEn),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdOk(rdOk)
  );

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [15:0] flags_reg, flags_next;
  logic [15:0] flagPol_reg, flagPol_next;
  logic [2:0] ctrl_reg, ctrl_next;
  logic [15:0] intEnable_reg, intEnable_next;
  logic [15:0] extEnable_reg, extEnable_next;
  logic [1:0] evtMask_reg, evtMask_next;
  logic [31:0] laneMask;
  logic [15:0] wrBits;

  // A write lands at the edge after the bus performs it; the request outputs follow one edge later.
  assign wrOk = known_offset(wrAddr);
  assign laneMask = lane_mask(wrStrb);
  // Only written lanes count, so a zero strobe lane never sets or clears a flag.
  assign wrBits = wrData[15:0] & laneMask[15:0];

  always_comb begin
    flags_next = flags_reg;
    flagPol_next = flagPol_reg;
    ctrl_next = ctrl_reg;
    intEnable_next = intEnable_reg;
    extEnable_next = extEnable_reg;
    evtMask_next = evtMask_reg;
    if (wrEn) begin
      case (wrAddr)
        irfo_pkg::OFS_FLAGS_DIRECT: begin
          flags_next = merge_lanes(flags_reg, laneMask[15:0], wrData[15:0]);
        end
        irfo_pkg::OFS_FLAGS_SETCLR: begin
          if (wrCore) begin
            flags_next = flags_reg | wrBits;
          end else begin
            flags_next = flags_reg & ~wrBits;
          end
        end
        irfo_pkg::OFS_FLAG_POL: begin
          flagPol_next = merge_lanes(flagPol_reg, laneMask[15:0], wrData[15:0]);
        end
        irfo_pkg::OFS_OUT_CTRL: begin
          ctrl_next = (ctrl_reg & ~laneMask[2:0]) | (wrData[2:0] & laneMask[2:0]);
        end
        irfo_pkg::OFS_INT_ENABLE: begin
          intEnable_next = merge_lanes(intEnable_reg, laneMask[15:0], wrData[15:0]);
        end
        irfo_pkg::OFS_EXT_ENABLE: begin
          extEnable_next = merge_lanes(extEnable_reg, laneMask[15:0], wrData[15:0]);
        end
        irfo_pkg::OFS_EVT_MASK: begin
          evtMask_next = (evtMask_reg & ~laneMask[1:0]) | (wrData[1:0] & laneMask[1:0]);
        end
        default: begin
          flags_next = flags_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags_reg <= irfo_pkg::FLAGS_RESET;
      flagPol_reg <= irfo_pkg::FLAG_POL_RESET;
      ctrl_reg <= irfo_pkg::CTRL_RESET;
      intEnable_reg <= irfo_pkg::INT_ENABLE_RESET;
      extEnable_reg <= irfo_pkg::EXT_ENABLE_RESET;
      evtMask_reg <= irfo_pkg::EVT_RESET;
    end else begin
      flags_reg <= flags_next;
      flagPol_reg <= flagPol_next;
      ctrl_reg <= ctrl_next;
      intEnable_reg <= intEnable_next;
      extEnable_reg <= extEnable_next;
      evtMask_reg <= evtMask_next;
    end
  end

  // ----------------------------------------------------------------
  // Request forming
  // ----------------------------------------------------------------
  logic [15:0] flagLevel;
  logic intRaw;
  logic extRaw;
  logic intLevel;
  logic extLevel;

  // Per-flag polarity lets a flag count as a cause while it is clear instead of set.
  for (genvar g = 0; g < irfo_pkg::FLAG_W; g++) begin : g_flag_level
    assign flagLevel[g] = flags_reg[g] ^ flagPol_reg[g];
  end

  // The invert bits act on the combined request, after the masks, so one setting covers all sixteen causes.
  assign intRaw = any_cause(flagLevel, intEnable_reg);
  assign extRaw = any_cause(flagLevel, extEnable_reg);
  assign intLevel = intRaw ^ ctrl_reg[irfo_pkg::CTRL_INT_INVERT_BIT];
  assign extLevel = extRaw ^ ctrl_reg[irfo_pkg::CTRL_EXT_INVERT_BIT];

  // ----------------------------------------------------------------
  // Pin driver and event status
  // ----------------------------------------------------------------
  logic intReq_reg, intReq_next;
  logic pinOut_reg, pinOut_next;
  logic pinOe_n_reg, pinOe_n_next;
  logic intRawPrev_reg, intRawPrev_next;
  logic extRawPrev_reg, extRawPrev_next;
  logic [1:0] evtStatus_reg, evtStatus_next;
  logic irq_reg, irq_next;
  logic [1:0] evtSet;
  logic statusRead;

  assign statusRead = rdEn && (rdAddr == irfo_pkg::OFS_EVT_STATUS);

  always_comb begin
    intReq_next = intLevel;
    intRawPrev_next = intRaw;
    extRawPrev_next = extRaw;
    // Value and enable of the pin change on the same edge, so a mode switch never drives stale data.
    if (ctrl_reg[irfo_pkg::CTRL_DRIVER_BIT]) begin
      pinOut_next = extLevel;
      pinOe_n_next = 1'b0;
    end else begin
      // Open drain only ever pulls low; the high level comes from the board pull-up.
      pinOut_next = 1'b0;
      pinOe_n_next = extLevel;
    end
    // Edge memories reset low like the raw causes, so the release of reset shows no false event.
    evtSet = 2'h0;
    evtSet[irfo_pkg::EVT_INT_BIT] = intRaw && !intRawPrev_reg;
    evtSet[irfo_pkg::EVT_EXT_BIT] = extRaw && !extRawPrev_reg;
    // A new event in the cycle of a clearing read survives the clear.
    evtStatus_next = (statusRead ? 2'h0 : evtStatus_reg) | evtSet;
    irq_next = |(evtStatus_next & evtMask_reg);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      intReq_reg <= irfo_pkg::INT_REQ_RESET;
      pinOut_reg <= irfo_pkg::PIN_OUT_RESET;
      pinOe_n_reg <= irfo_pkg::PIN_OE_N_RESET;
      intRawPrev_reg <= 1'b0;
      extRawPrev_reg <= 1'b0;
      evtStatus_reg <= irfo_pkg::EVT_RESET;
      irq_reg <= 1'b0;
    end else begin
      intReq_reg <= intReq_next;
      pinOut_reg <= pinOut_next;
      pinOe_n_reg <= pinOe_n_next;
      intRawPrev_reg <= intRawPrev_next;
      extRawPrev_reg <= extRawPrev_next;
      evtStatus_reg <= evtStatus_next;
      irq_reg <= irq_next;
    end
  end

  assign intRequest = intReq_reg;
  assign extRequestPinOut = pinOut_reg;
  assign extRequestPinOe_n = pinOe_n_reg;
  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    rdOk = known_offset(rdAddr);
    rdData = 32'h00000000;
    case (rdAddr)
      irfo_pkg::OFS_FLAGS_DIRECT: rdData[15:0] = flags_reg;
      irfo_pkg::OFS_FLAGS_SETCLR: rdData[15:0] = flags_reg;
      irfo_pkg::OFS_FLAG_POL: rdData[15:0] = flagPol_reg;
      irfo_pkg::OFS_OUT_CTRL: rdData[2:0] = ctrl_reg;
      irfo_pkg::OFS_INT_ENABLE: rdData[15:0] = intEnable_reg;
      irfo_pkg::OFS_EXT_ENABLE: rdData[15:0] = extEnable_reg;
      irfo_pkg::OFS_EVT_STATUS: rdData[1:0] = evtStatus_reg;
      irfo_pkg::OFS_EVT_MASK: rdData[1:0] = evtMask_reg;
      default: rdData = 32'h00000000;
    endcase
  end

endmodule : irfo_top
`default_nettype wire

// file: hdl/irfo_pkg.sv
// Package of offsets, field positions and reset values for the interrupt request flag output stage.
package irfo_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int FLAG_W = 16;
  localparam int STAT_W = 2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_FLAGS_DIRECT = 16'hf510;
  localparam logic [15:0] OFS_FLAGS_SETCLR = 16'hf514;
  localparam logic [15:0] OFS_FLAG_POL = 16'hf518;
  localparam logic [15:0] OFS_OUT_CTRL = 16'hf51c;
  localparam logic [15:0] OFS_INT_ENABLE = 16'hf520;
  localparam logic [15:0] OFS_EXT_ENABLE = 16'hf524;
  localparam logic [15:0] OFS_EVT_STATUS = 16'hf528;
  localparam logic [15:0] OFS_EVT_MASK = 16'hf52c;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_INT_INVERT_BIT = 0;
  localparam int CTRL_EXT_INVERT_BIT = 1;
  localparam int CTRL_DRIVER_BIT = 2;
  localparam int CTRL_W = 3;

  // ----------------------------------------------------------------
  // Event status fields
  // ----------------------------------------------------------------
  localparam int EVT_INT_BIT = 0;
  localparam int EVT_EXT_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] CTRL_RESET = 3'h3;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] FLAG_POL_RESET = 16'h0000;
  localparam logic [15:0] INT_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] EXT_ENABLE_RESET = 16'h0000;
  localparam logic [1:0] EVT_RESET = 2'h0;
  localparam logic INT_REQ_RESET = 1'h1;
  localparam logic PIN_OUT_RESET = 1'h0;
  localparam logic PIN_OE_N_RESET = 1'h1;

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : irfo_pkg

// file: hdl/irfo_axil_slave.sv
// AXI4-Lite slave front end that turns bus transfers into single-cycle register strobes.
`timescale 1ns/1ns
`default_nettype none
module irfo_axil_slave (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic awFromCore,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wrEn,
  output logic [15:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  output logic wrCore,
  input wire logic wrOk,
  output logic rdEn,
  output logic [15:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdOk
);

  // ----------------------------------------------------------------
  // Write channel state
  // ----------------------------------------------------------------
  logic awHeld_reg, awHeld_next;
  logic [15:0] awAddr_reg, awAddr_next;
  logic awCore_reg, awCore_next;
  logic wHeld_reg, wHeld_next;
  logic [31:0] wData_reg, wData_next;
  logic [3:0] wStrb_reg, wStrb_next;
  logic bValid_reg, bValid_next;
  logic [1:0] bResp_reg, bResp_next;
  logic awReady_reg, awReady_next;
  logic wReady_reg, wReady_next;

  always_comb begin
    awHeld_next = awHeld_reg;
    awAddr_next = awAddr_reg;
    awCore_next = awCore_reg;
    wHeld_next = wHeld_reg;
    wData_next = wData_reg;
    wStrb_next = wStrb_reg;
    bValid_next = bValid_reg;
    bResp_next = bResp_reg;
    wrEn = awHeld_reg && wHeld_reg && !bValid_reg;
    if (s_axi_awvalid && awReady_reg) begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
      awCore_next = awFromCore;
    end
    if (s_axi_wvalid && wReady_reg) begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    if (wrEn) begin
      awHeld_next = 1'b0;
      wHeld_next = 1'b0;
      bValid_next = 1'b1;
      bResp_next = wrOk ? irfo_pkg::RESP_OKAY : irfo_pkg::RESP_SLVERR;
    end
    if (bValid_reg && s_axi_bready) begin
      bValid_next = 1'b0;
    end
    awReady_next = !awHeld_next;
    wReady_next = !wHeld_next;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 16'h0000;
      awCore_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      bValid_reg <= 1'b0;
      bResp_reg <= irfo_pkg::RESP_OKAY;
      awReady_reg <= 1'b0;
      wReady_reg <= 1'b0;
    end else begin
      awHeld_reg <= awHeld_next;
      awAddr_reg <= awAddr_next;
      awCore_reg <= awCore_next;
      wHeld_reg <= wHeld_next;
      wData_reg <= wData_next;
      wStrb_reg <= wStrb_next;
      bValid_reg <= bValid_next;
      bResp_reg <= bResp_next;
      awReady_reg <= awReady_next;
      wReady_reg <= wReady_next;
    end
  end

  assign wrAddr = awAddr_reg;
  assign wrData = wData_reg;
  assign wrStrb = wStrb_reg;
  assign wrCore = awCore_reg;
  assign s_axi_awready = awReady_reg;
  assign s_axi_wready = wReady_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;

  // ----------------------------------------------------------------
  // Read channel state
  // ----------------------------------------------------------------
  logic arReady_reg, arReady_next;
  logic rValid_reg, rValid_next;
  logic [31:0] rData_reg, rData_next;
  logic [1:0] rResp_reg, rResp_next;

  always_comb begin
    arReady_next = arReady_reg;
    rValid_next = rValid_reg;
    rData_next = rData_reg;
    rResp_next = rResp_reg;
    rdEn = s_axi_arvalid && arReady_reg;
    if (rdEn) begin
      arReady_next = 1'b0;
      rValid_next = 1'b1;
      rData_next = rdOk ? rdData : 32'h00000000;
      rResp_next = rdOk ? irfo_pkg::RESP_OKAY : irfo_pkg::RESP_SLVERR;
    end else if (rValid_reg && s_axi_rready) begin
      rValid_next = 1'b0;
      arReady_next = 1'b1;
    end else if (!rValid_reg) begin
      arReady_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      arReady_reg <= 1'b0;
      rValid_reg <= 1'b0;
      rData_reg <= 32'h00000000;
      rResp_reg <= irfo_pkg::RESP_OKAY;
    end else begin
      arReady_reg <= arReady_next;
      rValid_reg <= rValid_next;
      rData_reg <= rData_next;
      rResp_reg <= rResp_next;
    end
  end

  assign rdAddr = s_axi_araddr;
  assign s_axi_arready = arReady_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;

endmodule : irfo_axil_slave
`default_nettype wire

// file: bench/irfo_asserts.sv
// Checker of bus handshakes and request outputs of the flag output stage.
`timescale 1ns/1ns
`default_nettype none
module irfo_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic intRequest,
  input wire logic extRequestPinOe_n
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rst_out;
    $rose(rstn) |-> intRequest && extRequestPinOe_n;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("request outputs wrong after reset");
  property p_aw_once;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_once: assert property (p_aw_once) else $error("address ready stayed up");
  property p_b_time;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_time: assert property (p_b_time) else $error("write answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_time;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_time: assert property (p_r_time) else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  // Requests only move as the result of a register write, never on their own.
  property p_int_cause;
    $changed(intRequest) |-> $past(s_axi_bvalid);
  endproperty
  a_int_cause: assert property (p_int_cause) else $error("internal request moved unprompted");
  property p_pin_cause;
    $changed(extRequestPinOe_n) |-> $past(s_axi_bvalid);
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("pin enable moved unprompted");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_int_fall: cover property ($fell(intRequest));
endmodule : irfo_asserts
bind irfo_top irfo_asserts irfo_asserts_i (
  .clk(clk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .intRequest(intRequest), .extRequestPinOe_n(extRequestPinOe_n)
);
`default_nettype wire

// file: bench/irfo_far_side.sv
// Model of the board wire that carries the external request.
`timescale 1ns/1ns
`default_nettype none
module irfo_far_side (
  input wire logic extRequestPinOut,
  input wire logic extRequestPinOe_n,
  output logic pinLevel
);
  // The pull-up lifts the wire whenever the pin lets go, as an open drain needs.
  assign pinLevel = extRequestPinOe_n ? 1'h1 : extRequestPinOut;
endmodule : irfo_far_side
`default_nettype wire

// file: bench/test_interrupt_request_flag_output.sv
// Self-checking bench of the flag output stage over its register bus and request outputs.
`timescale 1ns/1ns
`default_nettype none
module test_interrupt_request_flag_output;
  // ----------------------------------------------------------------
  // Stimulus and wiring
  // ----------------------------------------------------------------
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic [15:0] awaddr = 16'h0;
  logic [15:0] araddr = 16'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awFromCore = 1'h1;
  logic [31:0] rdv;
  logic [1:0] resp;
  int errCount = 0;
  int checks = 0;
  int cycles = 0;
  wire logic awready, wready, bvalid, arready, rvalid, intRequest, pinOut, pinOe_n, irq, pinLevel;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  irfo_top irfo_top_i (
    .clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .awFromCore(awFromCore), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .intRequest(intRequest),
    .extRequestPinOut(pinOut), .extRequestPinOe_n(pinOe_n), .irq(irq)
  );
  irfo_far_side irfo_far_side_i (.extRequestPinOut(pinOut), .extRequestPinOe_n(pinOe_n), .pinLevel(pinLevel));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      results;
    end
  end
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [31:0] d, input logic core);
    logic awDone;
    logic wDone;
    awDone = 1'h0;
    wDone = 1'h0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awFromCore <= core;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(awDone && wDone)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        awDone = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        wDone = 1'h1;
        wvalid <= 1'h0;
      end
    end
    // Ready is raised late on purpose so the answer has to wait.
    while (bvalid !== 1'h1) @(posedge clk);
    bready <= 1'h1;
    @(posedge clk);
    resp = bresp;
    bready <= 1'h0;
  endtask : wr
  task rd(input logic [15:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    @(posedge clk);
    while (arready !== 1'h1) @(posedge clk);
    arvalid <= 1'h0;
    while (rvalid !== 1'h1) @(posedge clk);
    rready <= 1'h1;
    @(posedge clk);
    rdv = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask : rd
  task rchk(input string what, input logic [15:0] a, input logic [31:0] exp);
    rd(a);
    chk(what, rdv, exp);
  endtask : rchk
  task settle;
    repeat (4) @(posedge clk);
    #1;
  endtask : settle
  task tReset;
    #1;
    chk("intRequest", 32'(intRequest), 32'h1);
    chk("oe_n", 32'(pinOe_n), 32'h1);
    rchk("ctrl", irfo_pkg::OFS_OUT_CTRL, 32'h3);
    rchk("intEn", irfo_pkg::OFS_INT_ENABLE, 32'h0);
    rchk("extEn", irfo_pkg::OFS_EXT_ENABLE, 32'h0);
    rchk("flags", irfo_pkg::OFS_FLAGS_DIRECT, 32'h0);
    $display("done reset");
  endtask : tReset
  task tReserved;
    wr(irfo_pkg::OFS_OUT_CTRL, 32'hffffffff, 1'h1);
    chk("bresp", 32'(resp), 32'(irfo_pkg::RESP_OKAY));
    rchk("ctrl", irfo_pkg::OFS_OUT_CTRL, 32'h7);
    wr(irfo_pkg::OFS_INT_ENABLE, 32'hffffffff, 1'h1);
    rchk("intEn", irfo_pkg::OFS_INT_ENABLE, 32'hffff);
    wr(irfo_pkg::OFS_EXT_ENABLE, 32'hffffffff, 1'h1);
    rchk("extEn", irfo_pkg::OFS_EXT_ENABLE, 32'hffff);
    wr(irfo_pkg::OFS_OUT_CTRL, 32'h3, 1'h1);
    $display("done reserved");
  endtask : tReserved
  task tFlags;
    wr(irfo_pkg::OFS_FLAGS_DIRECT, 32'hffffa5a5, 1'h1);
    rchk("flagsB", irfo_pkg::OFS_FLAGS_SETCLR, 32'ha5a5);
    wr(irfo_pkg::OFS_FLAGS_SETCLR, 32'h3, 1'h1);
    rchk("flagsA", irfo_pkg::OFS_FLAGS_DIRECT, 32'ha5a7);
    wr(irfo_pkg::OFS_FLAGS_SETCLR, 32'h5, 1'h0);
    wr(irfo_pkg::OFS_FLAGS_SETCLR, 32'h0, 1'h1);
    rchk("flagsA", irfo_pkg::OFS_FLAGS_DIRECT, 32'ha5a2);
    wr(irfo_pkg::OFS_FLAGS_DIRECT, 32'h0, 1'h0);
    rchk("flagsB", irfo_pkg::OFS_FLAGS_SETCLR, 32'h0);
    $display("done flags");
  endtask : tFlags
  task tOutputs;
    logic [15:0] f;
    logic il;
    logic el;
    wr(irfo_pkg::OFS_INT_ENABLE, 32'h10, 1'h1);
    wr(irfo_pkg::OFS_EXT_ENABLE, 32'h10, 1'h1);
    for (int k = 0; k < 16; k++) begin
      f = k[3] ? 16'h0010 : 16'h0008;
      wr(irfo_pkg::OFS_FLAGS_DIRECT, {16'h0, f}, 1'h1);
      wr(irfo_pkg::OFS_OUT_CTRL, {29'h0, k[2:0]}, 1'h1);
      settle;
      il = f[4] ^ k[0];
      el = f[4] ^ k[1];
      chk("intRequest", 32'(intRequest), 32'(il));
      chk("pin", 32'(pinLevel), 32'(el));
      chk("oe_n", 32'(pinOe_n), 32'(!k[2] && el));
    end
    wr(irfo_pkg::OFS_FLAG_POL, 32'h10, 1'h1);
    settle;
    chk("polarity", 32'(intRequest), 32'h1);
    wr(irfo_pkg::OFS_FLAG_POL, 32'h0, 1'h1);
    $display("done outputs");
  endtask : tOutputs
  task tIrq;
    wr(irfo_pkg::OFS_OUT_CTRL, 32'h0, 1'h1);
    wr(irfo_pkg::OFS_FLAGS_DIRECT, 32'h0, 1'h1);
    wr(irfo_pkg::OFS_INT_ENABLE, 32'h1, 1'h1);
    settle;
    rd(irfo_pkg::OFS_EVT_STATUS);
    wr(irfo_pkg::OFS_EVT_MASK, 32'h1, 1'h1);
    wr(irfo_pkg::OFS_FLAGS_SETCLR, 32'h1, 1'h1);
    settle;
    chk("irq", 32'(irq), 32'h1);
    rchk("status", irfo_pkg::OFS_EVT_STATUS, 32'h1);
    settle;
    chk("irq", 32'(irq), 32'h0);
    wr(irfo_pkg::OFS_EVT_MASK, 32'h0, 1'h1);
    wr(irfo_pkg::OFS_FLAGS_SETCLR, 32'h1, 1'h0);
    wr(irfo_pkg::OFS_FLAGS_DIRECT, 32'h1, 1'h0);
    settle;
    chk("irq", 32'(irq), 32'h0);
    rchk("status", irfo_pkg::OFS_EVT_STATUS, 32'h1);
    rchk("status", irfo_pkg::OFS_EVT_STATUS, 32'h0);
    $display("done irq");
  endtask : tIrq
  task tUnmapped;
    rd(16'hf530);
    chk("rresp", 32'(resp), 32'(irfo_pkg::RESP_SLVERR));
    chk("rdata", rdv, 32'h0);
    wr(16'hf530, 32'hffffffff, 1'h1);
    chk("bresp", 32'(resp), 32'(irfo_pkg::RESP_SLVERR));
    rchk("ctrl", irfo_pkg::OFS_OUT_CTRL, 32'h0);
    $display("done unmapped");
  endtask : tUnmapped
  task results;
    $display("checks %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'h1;
    tReset;
    tReserved;
    tFlags;
    tOutputs;
    tIrq;
    tUnmapped;
    results;
  end
endmodule : test_interrupt_request_flag_output
`default_nettype wire
